// ===== emu_lock_pkg.sv
package emu_lock_pkg;
  localparam int unsigned PORT_W = 8;
  localparam int unsigned KEY_DEPTH = 64;
  localparam int unsigned KEY_AW = 6;
  localparam logic [7:0] KEY_ERASED = 8'h00_FF;
  localparam logic [7:0] PORT_IDLE = 8'h00_FF;
  localparam int unsigned SETTLE_CYCLES = 6;
  typedef enum logic [1:0] {
    LOCK_NONE,
    LOCK_TABLE,
    LOCK_VERIFY,
    LOCK_EXEC
  } lock_level_e;
endpackage

// ===== emu_lock_if.sv
interface emu_lock_if;
  // address-latch strobe, open drain from the tester side
  logic ale_in;
  logic ale_out;
  logic ale_oe;
  logic ale_pull_up;
  logic tester_ale_drive_low;
  logic program_store_strobe_in;
  logic program_store_strobe_out;
  logic program_store_strobe_oe;
  logic program_store_strobe_pull_up;
  logic tester_pss_drive;
  logic tester_pss_level;
  logic [7:0] ad_port_out;
  logic ad_port_oe;
  logic [7:0] other_port_out;
  logic other_port_oe;
  logic other_port_pull_up;
  logic osc_run;
  logic reset_pin;
  logic external_access_pin;
  logic tester_drives_board;

  modport device (
    input ale_in, program_store_strobe_in, reset_pin, external_access_pin,
    output ale_out, ale_oe, ale_pull_up, program_store_strobe_out, program_store_strobe_oe,
    output program_store_strobe_pull_up, ad_port_out, ad_port_oe, other_port_out,
    output other_port_oe, other_port_pull_up, osc_run
  );
  modport tester (
    input ale_out, ale_oe, ad_port_oe, osc_run,
    output tester_ale_drive_low, tester_pss_drive, tester_pss_level, reset_pin,
    output external_access_pin, tester_drives_board
  );
endinterface

// ===== emu_lock_device.sv
module emu_lock_device
  import emu_lock_pkg::*;
#(
  parameter int unsigned KEYS = emu_lock_pkg::KEY_DEPTH
) (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_CE,
  emu_lock_if.device LINK,
  input wire logic I_PROTECT_BIT_A,
  input wire logic I_PROTECT_BIT_B,
  input wire logic I_PROTECT_BIT_C,
  input wire logic I_KEY_WE,
  input wire logic [emu_lock_pkg::KEY_AW-1:0] I_KEY_ADDR,
  input wire logic [7:0] I_KEY_DATA,
  input wire logic I_TABLE_READ_INSTRUCTION,
  input wire logic I_FETCH_EXTERNAL,
  input wire logic I_PROG_REQ,
  input wire logic I_VERIFY_REQ,
  input wire logic I_VERIFY_START,
  input wire logic [7:0] I_CODE_BYTE,
  input wire logic [7:0] I_AD_DATA,
  input wire logic I_AD_OE,
  input wire logic [7:0] I_PORT_DATA,
  input wire logic I_ALE_CORE,
  input wire logic I_PSS_CORE,
  output logic O_EMULATION,
  output logic [1:0] O_LOCK_LEVEL,
  output logic O_TABLE_READ_ALLOW,
  output logic O_PROG_ALLOW,
  output logic O_EXEC_ALLOW,
  output logic O_EXT_ACCESS,
  output logic O_VERIFY_VALID,
  output logic [7:0] O_VERIFY_DATA
);
  import emu_lock_pkg::*;

  // protection bits are programmed-low (P=0)
  logic ale_s1_q, ale_s2_q, pss_s1_q, pss_s2_q, rst_s1_q, rst_s2_q, ea_s1_q, ea_s2_q;
  logic rst_prev_q, emu_q, armed_q, ext_access_q;
  lock_level_e level_q;
  logic [7:0] key_mem [KEYS];
  logic [KEY_AW-1:0] key_idx_q;
  logic [KEYS-1:0] key_set_q;
  logic [7:0] key_w;
  logic release_w;

  function automatic lock_level_e decode_level(input logic a, input logic b, input logic c);
    // undefined patterns fall back to the strictest level
    if (a && b && c) return LOCK_NONE;
    else if (!a && b && c) return LOCK_TABLE;
    else if (!a && !b && c) return LOCK_VERIFY;
    else return LOCK_EXEC;
  endfunction

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      {ale_s1_q, ale_s2_q, pss_s1_q, pss_s2_q} <= 4'h0_F;
      {rst_s1_q, rst_s2_q, ea_s1_q, ea_s2_q} <= 4'h0_C;
    end else if (I_CE) begin
      ale_s1_q <= LINK.ale_in;
      ale_s2_q <= ale_s1_q;
      pss_s1_q <= LINK.program_store_strobe_in;
      pss_s2_q <= pss_s1_q;
      rst_s1_q <= LINK.reset_pin;
      rst_s2_q <= rst_s1_q;
      ea_s1_q <= LINK.external_access_pin;
      ea_s2_q <= ea_s1_q;
    end
  end

  assign release_w = rst_prev_q && !rst_s2_q;
  // unwritten keys read as erased, xnor with them passes the byte
  assign key_w = key_set_q[key_idx_q] ? key_mem[key_idx_q] : KEY_ERASED;

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      rst_prev_q <= 1'b1;
      armed_q <= 1'b0;
      emu_q <= 1'b0;
    end else if (I_CE) begin
      rst_prev_q <= rst_s2_q;
      if (rst_s2_q) begin
        emu_q <= 1'b0;
        armed_q <= !ale_s2_q && pss_s2_q;
      end else if (release_w) begin
        emu_q <= armed_q && !ale_s2_q;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      level_q <= LOCK_EXEC;
      ext_access_q <= 1'b0;
    end else if (I_CE) begin
      if (rst_s2_q) begin
        level_q <= decode_level(I_PROTECT_BIT_A, I_PROTECT_BIT_B, I_PROTECT_BIT_C);
        ext_access_q <= ea_s2_q;
      end else if (level_q == LOCK_NONE) begin
        ext_access_q <= ea_s2_q;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_CE && I_KEY_WE && level_q == LOCK_NONE) begin
      key_mem[I_KEY_ADDR] <= I_KEY_DATA;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      key_idx_q <= '0;
      key_set_q <= '0;
      O_VERIFY_VALID <= 1'b0;
      O_VERIFY_DATA <= PORT_IDLE;
    end else if (I_CE) begin
      if (I_KEY_WE && level_q == LOCK_NONE) key_set_q[I_KEY_ADDR] <= 1'b1;
      O_VERIFY_VALID <= 1'b0;
      if (I_VERIFY_START) begin
        key_idx_q <= '0;
      end else if (I_VERIFY_REQ && level_q < LOCK_VERIFY) begin
        O_VERIFY_VALID <= 1'b1;
        O_VERIFY_DATA <= ~(I_CODE_BYTE ^ key_w);
        key_idx_q <= (key_idx_q == KEY_AW'(KEYS - 1)) ? '0 : key_idx_q + 1'b1;
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      O_EMULATION <= 1'b0;
      O_LOCK_LEVEL <= 2'h3;
      O_TABLE_READ_ALLOW <= 1'b0;
      O_PROG_ALLOW <= 1'b0;
      O_EXEC_ALLOW <= 1'b0;
      O_EXT_ACCESS <= 1'b0;
    end else if (I_CE) begin
      O_EMULATION <= emu_q;
      O_LOCK_LEVEL <= level_q;
      O_TABLE_READ_ALLOW <= !(level_q != LOCK_NONE && I_FETCH_EXTERNAL && I_TABLE_READ_INSTRUCTION);
      O_PROG_ALLOW <= I_PROG_REQ && level_q == LOCK_NONE;
      O_EXEC_ALLOW <= !(level_q == LOCK_EXEC && I_FETCH_EXTERNAL);
      O_EXT_ACCESS <= ext_access_q;
    end
  end

  // pins: tester owns the board while emulating
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      LINK.ad_port_out <= PORT_IDLE;
      LINK.ad_port_oe <= 1'b0;
      LINK.other_port_out <= PORT_IDLE;
      LINK.other_port_oe <= 1'b0;
      LINK.other_port_pull_up <= 1'b1;
      LINK.ale_out <= 1'b1;
      LINK.ale_oe <= 1'b0;
      LINK.ale_pull_up <= 1'b1;
      LINK.program_store_strobe_out <= 1'b1;
      LINK.program_store_strobe_oe <= 1'b0;
      LINK.program_store_strobe_pull_up <= 1'b1;
      LINK.osc_run <= 1'b1;
    end else if (I_CE) begin
      LINK.ad_port_out <= I_AD_DATA;
      // entry is decided one cycle after release, so keep pins off then too
      LINK.ad_port_oe <= I_AD_OE && !emu_q && !rst_s2_q && !rst_prev_q;
      LINK.other_port_out <= I_PORT_DATA;
      LINK.other_port_oe <= !emu_q && !rst_s2_q && !rst_prev_q;
      LINK.other_port_pull_up <= 1'b1;
      LINK.ale_out <= I_ALE_CORE;
      LINK.ale_oe <= !emu_q && !rst_s2_q && !rst_prev_q;
      LINK.ale_pull_up <= 1'b1;
      LINK.program_store_strobe_out <= I_PSS_CORE;
      LINK.program_store_strobe_oe <= !emu_q && !rst_s2_q && !rst_prev_q;
      LINK.program_store_strobe_pull_up <= 1'b1;
      LINK.osc_run <= 1'b1;
    end
  end
endmodule

// ===== emu_lock_tester.sv
// tester end: requests emulation and then takes the board
module emu_lock_tester (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic I_CE,
  emu_lock_if.tester LINK,
  input wire logic I_REQ_EMU,
  input wire logic I_HOLD_RESET,
  input wire logic I_EA_LEVEL,
  output logic O_IN_EMULATION
);
  import emu_lock_pkg::*;

  logic [1:0] float_q;
  logic [2:0] settle_q;

  // device pins float for a few cycles after any release; wait before trusting it
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      settle_q <= 3'h0;
    end else if (I_CE) begin
      if (LINK.reset_pin) settle_q <= 3'h0;
      else if (settle_q != 3'(SETTLE_CYCLES)) settle_q <= settle_q + 3'h1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      LINK.reset_pin <= 1'b1;
      LINK.tester_ale_drive_low <= 1'b0;
      LINK.tester_pss_drive <= 1'b0;
      LINK.tester_pss_level <= 1'b1;
      LINK.external_access_pin <= 1'b1;
    end else if (I_CE) begin
      LINK.reset_pin <= I_HOLD_RESET;
      LINK.external_access_pin <= I_EA_LEVEL;
      // strobe held low through the release edge
      LINK.tester_ale_drive_low <= I_REQ_EMU;
      LINK.tester_pss_drive <= I_REQ_EMU && I_HOLD_RESET;
      LINK.tester_pss_level <= 1'b1;
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      float_q <= 2'h0;
      O_IN_EMULATION <= 1'b0;
      LINK.tester_drives_board <= 1'b0;
    end else if (I_CE) begin
      float_q <= {float_q[0], settle_q == 3'(SETTLE_CYCLES) && !LINK.ad_port_oe && !LINK.ale_oe && !I_HOLD_RESET};
      O_IN_EMULATION <= float_q[1];
      LINK.tester_drives_board <= float_q[1] && !I_HOLD_RESET;
    end
  end
endmodule

// ===== emu_lock_props.sv
module emu_lock_props (
  input wire logic I_CLK,
  input wire logic I_SRST,
  input wire logic ale_in,
  input wire logic ale_oe,
  input wire logic ale_pull_up,
  input wire logic program_store_strobe_in,
  input wire logic program_store_strobe_oe,
  input wire logic program_store_strobe_pull_up,
  input wire logic ad_port_oe,
  input wire logic other_port_oe,
  input wire logic other_port_pull_up,
  input wire logic osc_run,
  input wire logic reset_pin
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  sequence emu_req_s;
    ($fell(reset_pin) && program_store_strobe_in) ##0 (!ale_in)[*4];
  endsequence
  AST_OSC_RUN: assert property (osc_run) else $error("oscillator stopped");
  AST_PORT_PULL: assert property (!other_port_oe |-> other_port_pull_up) else $error("port not pulled");
  AST_ALE_PULL: assert property (!ale_oe |-> ale_pull_up) else $error("strobe not pulled");
  AST_PSS_PULL: assert property (!program_store_strobe_oe |-> program_store_strobe_pull_up)
    else $error("store strobe not pulled");
  AST_FLOAT_TOGETHER: assert property (!ale_oe |-> !ad_port_oe) else $error("port driven while strobe floats");
  AST_ENTRY: assert property (emu_req_s |-> (!ad_port_oe && !other_port_oe && !ale_oe)[*8])
    else $error("emulation not entered");
  AST_NORMAL: assert property (($fell(reset_pin) ##0 ale_in[*4]) |-> ##4 ale_oe)
    else $error("normal mode not entered");
  AST_HOLD: assert property (((!reset_pin)[*6] ##0 !ale_oe) |=> !ale_oe) else $error("emulation left early");
  COV_ENTRY: cover property (emu_req_s);
  COV_NORMAL: cover property ($fell(reset_pin) ##0 ale_in[*4]);
  COV_EXIT: cover property (!ale_oe ##1 $rose(reset_pin));
endmodule

// ===== emu_lock_device_test.sv
module emu_lock_device_test;
  timeunit 1ns;
  timeprecision 1ns;
  import emu_lock_pkg::*;
  logic clk = 0, srst = 1, ce = 1, pa = 1, pb = 1, pc = 1, kwe = 0, tri_ = 0, fext = 0, preq = 0;
  logic vreq = 0, vst = 0, req_emu = 0, hold = 0, ea = 1, emu, in_emu, trd, pal, ext, ex, vv;
  logic [5:0] kad = 0;
  logic [7:0] kdat = 0, code = 0, vd;
  logic [1:0] lvl;
  int num_errors = 0, checked = 0, cyc = 0;
  emu_lock_if link ();
  always #50 clk = ~clk;
  assign link.ale_in = link.tester_ale_drive_low ? 1'b0 : (link.ale_oe ? link.ale_out : 1'b1);
  assign link.program_store_strobe_in = link.tester_pss_drive ? link.tester_pss_level :
    (link.program_store_strobe_oe ? link.program_store_strobe_out : 1'b1);
  emu_lock_device emu_lock_device_i (.I_CLK(clk), .I_SRST(srst), .I_CE(ce), .LINK(link),
    .I_PROTECT_BIT_A(pa), .I_PROTECT_BIT_B(pb), .I_PROTECT_BIT_C(pc), .I_KEY_WE(kwe), .I_KEY_ADDR(kad),
    .I_KEY_DATA(kdat), .I_TABLE_READ_INSTRUCTION(tri_), .I_FETCH_EXTERNAL(fext), .I_PROG_REQ(preq),
    .I_VERIFY_REQ(vreq), .I_VERIFY_START(vst), .I_CODE_BYTE(code), .I_AD_DATA(8'h00_5A), .I_AD_OE(1'b1),
    .I_PORT_DATA(8'h00_C3), .I_ALE_CORE(1'b1), .I_PSS_CORE(1'b1), .O_EMULATION(emu), .O_LOCK_LEVEL(lvl),
    .O_TABLE_READ_ALLOW(trd), .O_PROG_ALLOW(pal), .O_EXEC_ALLOW(ex), .O_EXT_ACCESS(ext),
    .O_VERIFY_VALID(vv), .O_VERIFY_DATA(vd));
  emu_lock_tester emu_lock_tester_i (.I_CLK(clk), .I_SRST(srst), .I_CE(ce), .LINK(link),
    .I_REQ_EMU(req_emu), .I_HOLD_RESET(hold), .I_EA_LEVEL(ea), .O_IN_EMULATION(in_emu));
  emu_lock_props emu_lock_props_i (.I_CLK(clk), .I_SRST(srst), .ale_in(link.ale_in), .ale_oe(link.ale_oe),
    .ale_pull_up(link.ale_pull_up), .program_store_strobe_in(link.program_store_strobe_in),
    .program_store_strobe_oe(link.program_store_strobe_oe),
    .program_store_strobe_pull_up(link.program_store_strobe_pull_up), .ad_port_oe(link.ad_port_oe),
    .other_port_oe(link.other_port_oe), .other_port_pull_up(link.other_port_pull_up),
    .osc_run(link.osc_run), .reset_pin(link.reset_pin));
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic test_done();
    if (num_errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      num_errors++;
      test_done();
    end
  end
  task automatic pin_reset(input logic want_emu);
    req_emu = want_emu;
    hold = 1;
    repeat (6) @(negedge clk);
    hold = 0;
    repeat (10) @(negedge clk);
    req_emu = 0;
  endtask
  task automatic emu_test();
    pin_reset(1);
    chk("emulation", 1, emu);
    chk("tester sees emulation", 1, in_emu);
    chk("tester drives board", 1, link.tester_drives_board);
    chk("port float", 0, link.ad_port_oe);
    chk("port pull", 1, link.other_port_pull_up & link.ale_pull_up);
    repeat (20) @(negedge clk);
    chk("emulation held", 1, emu);
    pin_reset(0);
    chk("emulation left", 0, emu);
    chk("tester idle", 0, in_emu);
    chk("board released", 0, link.tester_drives_board);
    chk("port driven", 1, link.ad_port_oe);
    chk("port data", 8'h00_C3, link.other_port_out);
    chk("address data", 8'h00_5A, link.ad_port_out);
  endtask
  // last entry is an undefined pattern, expected to decode to the strictest level
  task automatic lock_test();
    logic [2:0] pat [5] = '{3'b111, 3'b011, 3'b001, 3'b000, 3'b010};
    logic [1:0] want;
    for (int i = 0; i < 5; i++) begin
      {pa, pb, pc} = pat[i];
      want = (i == 4) ? 2'd3 : i[1:0];
      ea = 1;
      pin_reset(0);
      {pa, pb, pc} = 3'b000;
      ea = 0;
      tri_ = 1;
      fext = 1;
      preq = 1;
      vreq = 1;
      repeat (5) @(negedge clk);
      chk("lock level", want, lvl);
      chk("table read", want == 0, trd);
      chk("prog allow", want == 0, pal);
      chk("exec allow", want != 3, ex);
      chk("ext access latched", want != 0, ext);
      chk("verify valid", want < 2, vv);
      {tri_, fext, preq, vreq} = 4'b0000;
    end
  endtask
  task automatic verify_test();
    logic [7:0] key [2] = '{8'h00_5A, 8'h00_3C};
    logic [7:0] cb [3] = '{8'h00_A5, 8'h00_0F, 8'h00_77};
    {pa, pb, pc} = 3'b111;
    pin_reset(0);
    for (int k = 0; k < 2; k++) begin
      kwe = 1;
      kad = k[5:0];
      kdat = key[k];
      @(negedge clk);
    end
    kwe = 0;
    vst = 1;
    @(negedge clk);
    vst = 0;
    for (int b = 0; b < 3; b++) begin
      code = cb[b];
      vreq = 1;
      @(negedge clk);
      vreq = 0;
      for (int w = 0; w < 8 && vv !== 1'b1; w++) @(negedge clk);
      chk("verify data", (b < 2) ? ~(cb[b] ^ key[b]) : cb[b], vd);
      @(negedge clk);
    end
  endtask
  initial begin
    repeat (20) @(negedge clk);
    srst = 0;
    emu_test();
    lock_test();
    verify_test();
    test_done();
  end
endmodule
